// ==== design/xfer_seq_pkg.sv ====
// constants, register map and state codes of the transfer sequencer
package xfer_seq_pkg;

    // ------------------------------------------------------------
    // interrupt sources and vector table
    // ------------------------------------------------------------
    localparam int NUM_SRC = 48;
    localparam int SRC_W = 6;
    localparam logic [15:0] VEC_MIN_BASE = 16'h00A0;
    localparam logic [15:0] VEC_MAX_BASE = 16'h0140;
    localparam logic [15:0] VEC_MAX_PTR_OFS = 16'h0002;
    localparam logic [SRC_W-1:0] SRC_SER1_RX = 6'h09;
    localparam logic [SRC_W-1:0] SRC_SER1_TX = 6'h0A;
    localparam logic [SRC_W-1:0] SRC_SER2_RX = 6'h0D;
    localparam logic [SRC_W-1:0] SRC_SER2_TX = 6'h0E;

    // ------------------------------------------------------------
    // settings block layout in memory and mode word fields
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_MODE = 16'h0000;
    localparam logic [15:0] OFS_SRC = 16'h0002;
    localparam logic [15:0] OFS_DST = 16'h0004;
    localparam logic [15:0] OFS_CNT = 16'h0006;
    localparam int MODE_SIZE_BIT = 15;
    localparam int MODE_SRC_STEP_BIT = 14;
    localparam int MODE_DST_STEP_BIT = 13;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] ADDR_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] ADDR_EN_LO = 12'h004;
    localparam logic [PADDR_W-1:0] ADDR_EN_HI = 12'h008;
    localparam logic [PADDR_W-1:0] ADDR_IRQ_STAT = 12'h00C;
    localparam logic [PADDR_W-1:0] ADDR_IRQ_EN = 12'h010;
    localparam logic [PADDR_W-1:0] ADDR_IRQ_CLR = 12'h014;
    localparam logic [PADDR_W-1:0] ADDR_STATE = 12'h018;
    localparam int CTRL_MAX_BIT = 0;
    localparam int CTRL_ON_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_W = 2;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_EXH_BIT = 1;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    localparam int STATE_SRC_LSB = 8;
    localparam int STATE_CNT_LSB = 16;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_VEC = 12'h002,
        ST_LD_MODE = 12'h004,
        ST_LD_SRC = 12'h008,
        ST_LD_DST = 12'h010,
        ST_LD_CNT = 12'h020,
        ST_RD_DATA = 12'h040,
        ST_WR_DATA = 12'h080,
        ST_WB_SRC = 12'h100,
        ST_WB_DST = 12'h200,
        ST_WB_CNT = 12'h400,
        ST_DONE = 12'h800
    } seq_state_t;

endpackage

// ==== design/mem_op_if.sv ====
// one memory access request and its answer between sequencer and bus port
`timescale 1ns/1ps
`default_nettype none
interface mem_op_if;
    logic go;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport ctl(output go, we, word, addr, wdata, input done, rdata);
    modport port(input go, we, word, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ==== design/mem_port.sv ====
// system memory bus port: one byte or word access per request
`timescale 1ns/1ps
`default_nettype none
module mem_port
    import xfer_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    mem_op_if.port op,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    logic word_r;

    // hold the request until acknowledged; even byte sits on the upper lane
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_be <= 2'h0;
            mem_wdata <= 16'h0000;
            word_r <= 1'b0;
            op.done <= 1'b0;
            op.rdata <= 16'h0000;
        end
        else
        begin
            op.done <= 1'b0;
            if (!mem_req && op.go)
            begin
                mem_req <= 1'b1;
                mem_we <= op.we;
                mem_addr <= op.addr;
                word_r <= op.word;
                if (op.word)
                begin
                    mem_be <= 2'h3;
                    mem_wdata <= op.wdata;
                end
                else
                begin
                    mem_be <= op.addr[0] ? 2'h1 : 2'h2;
                    mem_wdata <= {op.wdata[7:0], op.wdata[7:0]};
                end
            end
            else if (mem_req && mem_ack)
            begin
                mem_req <= 1'b0;
                op.done <= 1'b1;
                if (word_r)
                    op.rdata <= mem_rdata;
                else if (mem_addr[0])
                    op.rdata <= {8'h00, mem_rdata[7:0]};
                else
                    op.rdata <= {8'h00, mem_rdata[15:8]};
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/xfer_seq.sv ====
// interrupt driven transfer sequencer with apb control and status
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - read vector, then load settings block
// - one vector entry per serviceable source
// - clear pending at activation, except serial
// - serial pending cleared at holding register access
// - move once, step addresses, decrement count
// - write updated settings back in place
// - count zero hands interrupt to processor
// - settings addresses always lie in page 0
// - minimum mode vectors carry no page
// - vector addresses fixed per source
// - serial receive and transmit each have a fixed vector address
// - settings are four words: mode,source,destination,count
// - mode bit15 size, bits14/13 address steps
// - stored count zero means 65,536 moves
// - disabled sources go straight to processor
module xfer_seq
    import xfer_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [NUM_SRC-1:0] src_pending,
    output logic [NUM_SRC-1:0] pending_clear,
    output logic [NUM_SRC-1:0] cpu_request,
    input wire logic [NUM_SRC-1:0] cpu_ack,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] vec_addr(input logic [SRC_W-1:0] s,
                                             input logic max_mode);
        if (max_mode)
            vec_addr = VEC_MAX_BASE + {8'h00, s, 2'b00} + VEC_MAX_PTR_OFS;
        else
            vec_addr = VEC_MIN_BASE + {9'h000, s, 1'b0};
    endfunction

    function automatic logic is_rx(input logic [SRC_W-1:0] s);
        is_rx = (s == SRC_SER1_RX) || (s == SRC_SER2_RX);
    endfunction

    function automatic logic is_tx(input logic [SRC_W-1:0] s);
        is_tx = (s == SRC_SER1_TX) || (s == SRC_SER2_TX);
    endfunction

    function automatic logic [SRC_W-1:0] pick_src(
        input logic [NUM_SRC-1:0] v);
        pick_src = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
            if (v[i])
                pick_src = SRC_W'(i);
    endfunction

    mem_op_if mo();

    seq_state_t st_r;
    logic wait_r;
    logic go_r;
    logic we_r;
    logic word_r;
    logic [15:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] ptr_r;
    logic [15:0] mode_r;
    logic [15:0] src_r;
    logic [15:0] dst_r;
    logic [15:0] cnt_r;
    logic [15:0] data_r;
    logic [SRC_W-1:0] cur_r;
    logic [1:0] ctrl_r;
    logic [NUM_SRC-1:0] en_r;
    logic [NUM_SRC-1:0] hold_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_en_r;
    logic [NUM_SRC-1:0] serviced;
    logic [15:0] step;
    logic fin_now;
    logic apb_wr;

    assign mo.go = go_r;
    assign mo.we = we_r;
    assign mo.word = word_r;
    assign mo.addr = addr_r;
    assign mo.wdata = wdata_r;

    // requests that this block takes instead of the processor
    assign serviced = src_pending & en_r & {NUM_SRC{ctrl_r[CTRL_ON_BIT]}};
    assign step = mode_r[MODE_SIZE_BIT] ? STEP_WORD : STEP_BYTE;
    assign fin_now = (st_r == ST_DONE);
    assign apb_wr = psel && penable && pready && pwrite;

    mem_port u_port (
        .mclk(mclk),
        .rst(rst),
        .op(mo.port),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_be(mem_be),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    // ------------------------------------------------------------
    // sequencer: vector, load, move, write back
    // ------------------------------------------------------------
    // each memory state issues one request, then waits for its answer
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= ST_IDLE;
            wait_r <= 1'b0;
            go_r <= 1'b0;
            we_r <= 1'b0;
            word_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            ptr_r <= 16'h0000;
            mode_r <= 16'h0000;
            src_r <= 16'h0000;
            dst_r <= 16'h0000;
            cnt_r <= 16'h0000;
            data_r <= 16'h0000;
            cur_r <= '0;
            pending_clear <= '0;
        end
        else
        begin
            go_r <= 1'b0;
            pending_clear <= '0;
            case (st_r)
                ST_IDLE:
                begin
                    if (|serviced)
                    begin
                        cur_r <= pick_src(serviced);
                        st_r <= ST_VEC;
                        if (!is_rx(pick_src(serviced)) &&
                            !is_tx(pick_src(serviced)))
                            pending_clear[pick_src(serviced)] <= 1'b1;
                    end
                end
                ST_DONE:
                    st_r <= ST_IDLE;
                default:
                begin
                    if (!wait_r)
                    begin
                        go_r <= 1'b1;
                        wait_r <= 1'b1;
                        we_r <= st_r inside {ST_WR_DATA, ST_WB_SRC,
                                             ST_WB_DST, ST_WB_CNT};
                        word_r <= !(st_r inside {ST_RD_DATA, ST_WR_DATA}) ||
                                  mode_r[MODE_SIZE_BIT];
                        case (st_r)
                            ST_VEC:
                                addr_r <= vec_addr(cur_r, ctrl_r[CTRL_MAX_BIT]);
                            ST_LD_MODE:
                                addr_r <= ptr_r + OFS_MODE;
                            ST_LD_SRC, ST_WB_SRC:
                                addr_r <= ptr_r + OFS_SRC;
                            ST_LD_DST, ST_WB_DST:
                                addr_r <= ptr_r + OFS_DST;
                            ST_RD_DATA:
                                addr_r <= src_r;
                            ST_WR_DATA:
                                addr_r <= dst_r;
                            default:
                                addr_r <= ptr_r + OFS_CNT;
                        endcase
                        case (st_r)
                            ST_WR_DATA:
                                wdata_r <= data_r;
                            ST_WB_SRC:
                                wdata_r <= src_r;
                            ST_WB_DST:
                                wdata_r <= dst_r;
                            default:
                                wdata_r <= cnt_r;
                        endcase
                    end
                    else if (mo.done)
                    begin
                        wait_r <= 1'b0;
                        case (st_r)
                            ST_VEC:
                            begin
                                ptr_r <= mo.rdata; // page 0 only
                                st_r <= ST_LD_MODE;
                            end
                            ST_LD_MODE:
                            begin
                                mode_r <= mo.rdata;
                                st_r <= ST_LD_SRC;
                            end
                            ST_LD_SRC:
                            begin
                                src_r <= mo.rdata;
                                st_r <= ST_LD_DST;
                            end
                            ST_LD_DST:
                            begin
                                dst_r <= mo.rdata;
                                st_r <= ST_LD_CNT;
                            end
                            ST_LD_CNT:
                            begin
                                cnt_r <= mo.rdata;
                                st_r <= ST_RD_DATA;
                            end
                            ST_RD_DATA:
                            begin
                                data_r <= mo.rdata;
                                if (is_rx(cur_r))
                                    pending_clear[cur_r] <= 1'b1;
                                st_r <= ST_WR_DATA;
                            end
                            ST_WR_DATA:
                            begin
                                if (is_tx(cur_r))
                                    pending_clear[cur_r] <= 1'b1;
                                if (mode_r[MODE_SRC_STEP_BIT])
                                    src_r <= src_r + step;
                                if (mode_r[MODE_DST_STEP_BIT])
                                    dst_r <= dst_r + step;
                                cnt_r <= cnt_r - COUNT_ONE; // zero wraps
                                st_r <= ST_WB_SRC;
                            end
                            ST_WB_SRC:
                                st_r <= ST_WB_DST;
                            ST_WB_DST:
                                st_r <= ST_WB_CNT;
                            default:
                                st_r <= ST_DONE;
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // processor hand-off
    // ------------------------------------------------------------
    // exhausted count holds the request until the processor acknowledges
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            hold_r <= '0;
            cpu_request <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_SRC; i++)
                if (fin_now && cnt_r == 16'h0000 && cur_r == SRC_W'(i))
                    hold_r[i] <= 1'b1;
                else if (cpu_ack[i])
                    hold_r[i] <= 1'b0;
            cpu_request <= hold_r | (src_pending & ~serviced);
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait state, then pready
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (paddr == ADDR_CTRL)
                prdata <= {30'h0000_0000, ctrl_r};
            else if (paddr == ADDR_EN_LO)
                prdata <= en_r[31:0];
            else if (paddr == ADDR_EN_HI)
                prdata <= {16'h0000, en_r[NUM_SRC-1:32]};
            else if (paddr == ADDR_IRQ_STAT)
                prdata <= {30'h0000_0000, stat_r};
            else if (paddr == ADDR_IRQ_EN)
                prdata <= {30'h0000_0000, stat_en_r};
            else if (paddr == ADDR_IRQ_CLR)
                prdata <= 32'h0000_0000;
            else if (paddr == ADDR_STATE)
                prdata <= {cnt_r, 2'h0, cur_r, 7'h00, st_r != ST_IDLE};
            else
                pslverr <= 1'b1;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // software control registers, written at the completing edge
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RST;
            en_r <= '0;
            stat_en_r <= STAT_RST;
        end
        else if (apb_wr)
        begin
            if (paddr == ADDR_CTRL)
                ctrl_r <= pwdata[1:0];
            else if (paddr == ADDR_EN_LO)
                en_r[31:0] <= pwdata;
            else if (paddr == ADDR_EN_HI)
                en_r[NUM_SRC-1:32] <= pwdata[15:0];
            else if (paddr == ADDR_IRQ_EN)
                stat_en_r <= pwdata[STAT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // event status and interrupt line
    // ------------------------------------------------------------
    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stat_r <= STAT_RST;
            irq <= 1'b0;
        end
        else
        begin
            for (int b = 0; b < STAT_W; b++)
            begin
                if (apb_wr && paddr == ADDR_IRQ_CLR && pwdata[b])
                    stat_r[b] <= 1'b0;
                if (fin_now && b == STAT_ACT_BIT)
                    stat_r[b] <= 1'b1;
                if (fin_now && cnt_r == 16'h0000 && b == STAT_EXH_BIT)
                    stat_r[b] <= 1'b1;
            end
            irq <= |(stat_r & stat_en_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence vec_issue_s;
        st_r == ST_VEC && go_r;
    endsequence

    sequence cnt_issue_s;
        st_r inside {ST_LD_CNT, ST_WB_CNT} && go_r;
    endsequence

    vec_addr_a: assert property (vec_issue_s |->
        addr_r == (ctrl_r[CTRL_MAX_BIT] ?
        VEC_MAX_BASE + VEC_MAX_PTR_OFS + 16'(cur_r) * 16'h0004 :
        VEC_MIN_BASE + 16'(cur_r) * 16'h0002))
        else $error("vector fetched from wrong address");
    cnt_word_a: assert property (cnt_issue_s |->
        addr_r == ptr_r + OFS_CNT)
        else $error("count word at wrong offset");
    act_clear_a: assert property ($rose(st_r == ST_VEC) &&
        !is_rx(cur_r) && !is_tx(cur_r) |-> pending_clear[cur_r])
        else $error("activating source not cleared");
    serial_keep_a: assert property ($rose(st_r == ST_VEC) &&
        (is_rx(cur_r) || is_tx(cur_r)) |-> pending_clear == '0)
        else $error("serial source cleared too early");
    count_dec_a: assert property (st_r == ST_WR_DATA &&
        wait_r && mo.done |=> cnt_r == $past(cnt_r) - COUNT_ONE)
        else $error("count not decremented after move");
    src_step_a: assert property (st_r == ST_WR_DATA &&
        wait_r && mo.done |=> src_r == $past(src_r) +
        (!$past(mode_r[MODE_SRC_STEP_BIT]) ? 16'h0000 :
        $past(mode_r[MODE_SIZE_BIT]) ? STEP_WORD : STEP_BYTE))
        else $error("source address stepped wrongly");
    wb_data_a: assert property (st_r == ST_WB_SRC && go_r |->
        we_r && wdata_r == src_r && addr_r == ptr_r + OFS_SRC)
        else $error("source write back wrong");
    handoff_a: assert property (fin_now && cnt_r == 16'h0000
        |=> hold_r[$past(cur_r)] ##1 cpu_request[$past(cur_r, 2)])
        else $error("exhausted count not handed to processor");
    one_at_time_a: assert property (st_r != ST_IDLE && !fin_now
        |=> $stable(cur_r))
        else $error("source changed during activation");
    gate_a: assert property ($rose(st_r == ST_VEC) |->
        en_r[cur_r] && $past(ctrl_r[CTRL_ON_BIT]))
        else $error("disabled source activated sequencer");

endmodule
`default_nettype wire

// ==== tb/mem_model.sv ====
// behavioural page 0 memory answering the sequencer's bus port
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_wdata,
    input wire logic [3:0] wait_cyc,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    // whole 16 bit space is page 0, writable, so any block works
    logic [15:0] mem [0:32767];
    logic [3:0] cnt_r;
    // answer after wait_cyc cycles; read lines churn outside acks
    always @(posedge mclk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= rst ? 16'h0000 : ~mem_rdata;
        cnt_r <= 4'h0;
        if (!rst && mem_req && !mem_ack && cnt_r != wait_cyc)
            cnt_r <= cnt_r + 4'h1;
        else if (!rst && mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[15:1]];
            if (mem_we && mem_be[1])
                mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
            if (mem_we && mem_be[0])
                mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
        end
    end
endmodule
`default_nettype wire

// ==== tb/xfer_seq_tb.sv ====
// self-checking bench for the transfer sequencer
`timescale 1ns/1ps
`default_nettype none
module xfer_seq_tb;
    import xfer_seq_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, err;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [NUM_SRC-1:0] src_pending = '0, cpu_ack = '0, clr_seen = '0;
    logic [NUM_SRC-1:0] pend_prev = '0;
    logic [NUM_SRC-1:0] pending_clear, cpu_request;
    logic mem_req, mem_we, mem_ack;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [1:0] mem_be;
    logic [3:0] wait_cyc = 4'h0;
    int fails = 0, checks = 0, cyc = 0;
    xfer_seq dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .src_pending, .pending_clear,
        .cpu_request, .cpu_ack, .mem_req, .mem_we, .mem_addr, .mem_be,
        .mem_wdata, .mem_rdata, .mem_ack);
    mem_model partner (.mclk, .rst, .mem_req, .mem_we, .mem_addr, .mem_be,
        .mem_wdata, .wait_cyc, .mem_rdata, .mem_ack);
    initial forever #10 mclk = ~mclk;
    // pending levels drop on clear pulses; cycle ceiling cuts hangs short
    always @(posedge mclk)
    begin
        if (|pending_clear)
            src_pending <= src_pending & ~pending_clear;
        // a fresh pending edge forgets that source's earlier clear
        clr_seen <= (clr_seen & ~(src_pending & ~pend_prev)) | pending_clear;
        pend_prev <= src_pending;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic activate(input int slot);
        src_pending[slot] <= 1'b1;
        rd = '0;
        while (rd[STAT_ACT_BIT] !== 1'b1)
            apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        apb(1'b1, ADDR_IRQ_CLR, 32'h1);
    endtask
    task automatic reset_values;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0, "ctrl");
        apb(1'b0, ADDR_STATE, 32'h0);
        chk(rd, 32'h0, "state");
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1, "unmapped");
        apb(1'b0, ADDR_IRQ_CLR, 32'h0);
        chk(rd, 32'h0, "clr read");
        $display("test reset_values done");
    endtask
    task automatic word_move;
        partner.mem[16'h0060] = 16'h0400;
        partner.mem[16'h0200] = 16'hE000;
        partner.mem[16'h0201] = 16'h0500;
        partner.mem[16'h0202] = 16'h0600;
        partner.mem[16'h0203] = 16'h0002;
        partner.mem[16'h0280] = 16'hA55A;
        partner.mem[16'h0281] = 16'h1234;
        apb(1'b1, ADDR_EN_LO, 32'h0001_0000);
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_IRQ_EN, 32'h2);
        activate(16);
        chk(partner.mem[16'h0300], 16'hA55A, "move");
        chk(partner.mem[16'h0201], 16'h0502, "src");
        chk(partner.mem[16'h0202], 16'h0602, "dst");
        chk(partner.mem[16'h0203], 16'h0001, "cnt");
        chk(clr_seen[16], 1'b1, "clear");
        chk({cpu_request[16], irq}, 2'h0, "early");
        activate(16);
        chk(partner.mem[16'h0301], 16'h1234, "move2");
        chk(partner.mem[16'h0203], 16'h0000, "cnt2");
        chk({cpu_request[16], irq}, 2'h3, "handoff");
        apb(1'b1, ADDR_IRQ_CLR, 32'h3);
        cpu_ack[16] <= 1'b1;
        @(posedge mclk);
        cpu_ack[16] <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({cpu_request[16], irq}, 2'h0, "ack");
        $display("test word_move done");
    endtask
    task automatic serial_byte_max;
        wait_cyc <= 4'h3;
        partner.mem[16'h00B2] = 16'h00FF;
        partner.mem[16'h00B3] = 16'h0440;
        partner.mem[16'h0220] = 16'h2000;
        partner.mem[16'h0221] = 16'h0101;
        partner.mem[16'h0222] = 16'h0700;
        partner.mem[16'h0223] = 16'h0000;
        partner.mem[16'h0080] = 16'h77C3;
        apb(1'b1, ADDR_EN_LO, 32'h0000_0200);
        apb(1'b1, ADDR_CTRL, 32'h3);
        activate(9);
        chk(partner.mem[16'h0380][15:8], 8'hC3, "byte");
        chk(partner.mem[16'h0221], 16'h0101, "src");
        chk(partner.mem[16'h0222], 16'h0701, "dst");
        chk(partner.mem[16'h0223], 16'hFFFF, "cnt");
        chk({clr_seen[9], cpu_request[9]}, 2'h2, "serial");
        // transmit source reuses the block: odd destination, lower lane
        partner.mem[16'h00B5] = 16'h0440;
        apb(1'b1, ADDR_EN_LO, 32'h0000_0400);
        activate(10);
        chk(partner.mem[16'h0380], 16'hC3C3, "tx byte");
        chk({clr_seen[10], partner.mem[16'h0223]}, 17'h1FFFE, "tx");
        wait_cyc <= 4'h0;
        $display("test serial_byte_max done");
    endtask
    task automatic disabled_source;
        apb(1'b1, ADDR_EN_LO, 32'h0);
        src_pending[20] <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({cpu_request[20], mem_req}, 2'h2, "bypass");
        src_pending[20] <= 1'b0;
        $display("test disabled_source done");
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        reset_values;
        word_move;
        serial_byte_max;
        disabled_source;
        finish_test;
    end
endmodule
`default_nettype wire
